// ==== rtl/pfm_pkg.sv ====
// Pad function mux: constants, pad mode type, shared decode helpers.
// Assumes one clock domain and byte addressed Avalon-MM register access.
// Overview of operation
// R1 - With no routed function and no fixed-pin peripheral active, pads 0-3 go to JTAG.
// R2 - JTAG uses pad 0 for data out, 1 for data in, 2 for mode select, 3 for clock.
// R3 - Analog enable switches pads 11-15 and 18-20 onto the analog lines.
// R4 - Analog lines 0-4 and 9 feed the converter, lines 7 and 8 feed the amplifier.
// R5 - Each pad 0-34 has a route enable bit over two registers; software keeps bit 8 clear.
// R6 - Each pad has a 6-bit function code, four per register at bits 5:0, 13:8, 21:16, 29:24.
// R7 - GPIO enable bits cover pads 0-3 and 14-16 at the same bit numbers, all reset to zero.
// R8 - An active fixed-pin peripheral takes its pads away from the default mapping.
// R9 - Function codes 0 to 40 each name one peripheral signal.
// R10 - Pad 8 is the test-mode input and is never driven.
// R11 - Key scan ties each pad to its fixed matrix line; pads 16 and 17 serve the crystal. Code: no line on pad 8; key scan (16/17) and GPIO (16) win first.
// R12 - A routed pad uses its code, else its enabled fixed-pin peripheral, else the default.
package pfm_pkg;

    localparam int PFM_PADS      = 35;
    localparam int PFM_CODES     = 41;
    localparam int PFM_CW        = 6;
    localparam int PFM_ANA_W     = 10;
    localparam int PFM_TEST_PAD  = 8;
    localparam int PFM_KIN_W     = 16;
    localparam int PFM_KOUT_W    = 18;
    localparam int PFM_GPIO_W    = 17;
    localparam int PFM_FSEL_REGS = 9;
    localparam int PFM_SLOT_STEP = 8;
    localparam int PFM_JTAG_PADS = 4;
    localparam int PFM_XTAL_I    = 16;
    localparam int PFM_XTAL_O    = 17;

    // ----------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------
    localparam logic [7:0]  PFM_OFS_ANALOG = 8'h00;
    localparam logic [7:0]  PFM_OFS_MUX_LO = 8'h0C;
    localparam logic [7:0]  PFM_OFS_MUX_HI = 8'h10;
    localparam logic [7:0]  PFM_OFS_GPIO   = 8'h14;
    localparam logic [7:0]  PFM_OFS_FSEL0  = 8'h18;
    localparam logic [7:0]  PFM_OFS_KSCAN  = 8'h3C;
    localparam logic [9:0]  PFM_ANALOG_RST = 10'h060;
    localparam logic [16:0] PFM_GPIO_MASK  = 17'h1C00F;

    typedef enum logic [2:0] {
        PM_FUNC, PM_ANALOG, PM_KEY, PM_GPIO, PM_XTAL, PM_JTAG, PM_OFF
    } pfm_mode_t;

    // Analog line per pad: {valid, line}
    localparam logic [4:0] PFM_ANA [PFM_PADS] = '{
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
        5'h00, 5'h00, 5'h17, 5'h18, 5'h19, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00};

    // Key matrix line per pad: {valid, is_output, index}
    localparam logic [6:0] PFM_KM [PFM_PADS] = '{
        7'h40, 7'h60, 7'h41, 7'h61, 7'h69, 7'h4A, 7'h6A, 7'h4B,
        7'h00, 7'h64, 7'h44, 7'h6B, 7'h4C, 7'h6C, 7'h62, 7'h42,
        7'h70, 7'h71, 7'h45, 7'h4D, 7'h65, 7'h6D, 7'h4E, 7'h46,
        7'h63, 7'h43, 7'h6E, 7'h49, 7'h68, 7'h4F, 7'h6F, 7'h67,
        7'h47, 7'h66, 7'h48};

    function automatic logic [31:0] pfm_be_mask(input logic [3:0] be);
        pfm_be_mask = '0;
        for (int b = 0; b < 4; b++) begin
            pfm_be_mask[8*b +: 8] = {8{be[b]}};
        end
    endfunction

    function automatic logic pfm_code_ok(input logic [5:0] c);
        pfm_code_ok = (32'(c) < PFM_CODES);
    endfunction

endpackage

// ==== rtl/pfm_pad_select.sv ====
// Pad function mux: per-pad mode choice from the configuration.
// Assumes configuration arrives from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_select (
    input  wire logic [pfm_pkg::PFM_ANA_W-1:0]  ana_en,
    input  wire logic [pfm_pkg::PFM_PADS-1:0]   mux_en,
    input  wire logic [pfm_pkg::PFM_GPIO_W-1:0] gpio_en,
    input  wire logic                           kscan_en,
    input  wire logic                           xtal_in_use,
    output pfm_pkg::pfm_mode_t                  pad_mode [pfm_pkg::PFM_PADS]
);
    import pfm_pkg::*;

    always_comb begin
        for (int p = 0; p < PFM_PADS; p++) begin
            if (p == PFM_TEST_PAD) begin
                pad_mode[p] = PM_OFF; // R10
            end else if (mux_en[p]) begin
                pad_mode[p] = PM_FUNC; // R12
            end else if (PFM_ANA[p][4] && ana_en[PFM_ANA[p][3:0]]) begin
                pad_mode[p] = PM_ANALOG; // R3
            end else if (kscan_en && PFM_KM[p][6]) begin
                pad_mode[p] = PM_KEY; // R11
            end else if (p < PFM_GPIO_W && PFM_GPIO_MASK[p % PFM_GPIO_W]
                         && gpio_en[p % PFM_GPIO_W]) begin
                pad_mode[p] = PM_GPIO; // R8
            end else if (xtal_in_use && (p == PFM_XTAL_I || p == PFM_XTAL_O)) begin
                pad_mode[p] = PM_XTAL; // R11
            end else if (p < PFM_JTAG_PADS) begin
                pad_mode[p] = PM_JTAG; // R1
            end else begin
                pad_mode[p] = PM_GPIO;
            end
        end
    end

endmodule
`default_nettype wire

// ==== rtl/pfm_input_route.sv ====
// Pad function mux: pad levels back to the peripherals, by pad mode.
// Assumes pad inputs are already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pfm_input_route (
    input  wire logic [pfm_pkg::PFM_PADS-1:0] pad_in,
    input  var pfm_pkg::pfm_mode_t            pad_mode [pfm_pkg::PFM_PADS],
    input  wire logic [pfm_pkg::PFM_CW-1:0]   pad_code [pfm_pkg::PFM_PADS],
    output logic [pfm_pkg::PFM_CODES-1:0]     func_in_next,
    output logic [pfm_pkg::PFM_KIN_W-1:0]     key_in_next,
    output logic [pfm_pkg::PFM_PADS-1:0]      gpio_in_next,
    output logic [2:0]                        jtag_in_next
);
    import pfm_pkg::*;

    // Descending walk: the lowest pad wins a shared code
    always_comb begin
        func_in_next = '0;
        key_in_next  = '0;
        gpio_in_next = '0;
        jtag_in_next = '0;
        for (int p = PFM_PADS - 1; p >= 0; p--) begin
            case (pad_mode[p])
                PM_FUNC: begin
                    if (pfm_code_ok(pad_code[p])) begin
                        func_in_next[pad_code[p]] = pad_in[p]; // R9
                    end
                end
                PM_KEY: begin
                    if (!PFM_KM[p][5]) begin
                        key_in_next[PFM_KM[p][3:0]] = pad_in[p]; // R11
                    end
                end
                PM_GPIO: gpio_in_next[p] = pad_in[p];
                PM_JTAG: begin
                    if (p > 0) begin
                        jtag_in_next[(p - 1) % 3] = pad_in[p]; // R2
                    end
                end
                default: ;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== rtl/pfm_top.sv ====
// Pad function mux top: Avalon-MM registers, pad drive, returned inputs.
// Assumes peripherals, TAP and pads share ref_clk; pad wire built outside.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pfm_top (
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire logic [7:0]                     avs_address,
    input  wire logic                           avs_read,
    input  wire logic                           avs_write,
    input  wire logic [31:0]                    avs_writedata,
    input  wire logic [3:0]                     avs_byteenable,
    output logic [31:0]                         avs_readdata,
    output logic                                avs_waitrequest,
    input  wire logic [pfm_pkg::PFM_PADS-1:0]   pad_in,
    output logic [pfm_pkg::PFM_PADS-1:0]        pad_out,
    output logic [pfm_pkg::PFM_PADS-1:0]        pad_oe,
    output logic [pfm_pkg::PFM_PADS-1:0]        analog_pad_connect,
    output logic [5:0]                          adc_input_connect,
    output logic [1:0]                          pga_input_connect,
    input  wire logic [pfm_pkg::PFM_CODES-1:0]  func_out,
    input  wire logic [pfm_pkg::PFM_CODES-1:0]  func_oe,
    output logic [pfm_pkg::PFM_CODES-1:0]       func_in,
    input  wire logic [pfm_pkg::PFM_PADS-1:0]   gpio_out,
    input  wire logic [pfm_pkg::PFM_PADS-1:0]   gpio_oe,
    output logic [pfm_pkg::PFM_PADS-1:0]        gpio_in,
    input  wire logic [pfm_pkg::PFM_KOUT_W-1:0] keymatrix_output,
    output logic [pfm_pkg::PFM_KIN_W-1:0]       keymatrix_input,
    input  wire logic                           test_data_out,
    input  wire logic                           test_data_out_oe,
    output logic                                test_data_in,
    output logic                                test_mode_select,
    output logic                                test_clock,
    input  wire logic                           xtal_in_use
);
    import pfm_pkg::*;

    localparam logic [5:0] FSEL_W0 = PFM_OFS_FSEL0[7:2];

    logic [PFM_ANA_W-1:0]  ana_en_reg;
    logic [PFM_PADS-1:0]   mux_en_reg;
    logic [PFM_GPIO_W-1:0] gpio_en_reg;
    logic [PFM_CW-1:0]     code_reg [PFM_PADS];
    logic                  kscan_en_reg;
    logic                  req;
    logic [31:0]           rd_img;
    logic [31:0]           wr_img;
    logic [31:0]           be_m;
    logic [5:0]            fsel_word;
    logic                  fsel_hit;
    int                    fsel_base;
    pfm_mode_t             pad_mode [PFM_PADS];
    logic [PFM_PADS-1:0]   pad_out_next;
    logic [PFM_PADS-1:0]   pad_oe_next;
    logic [PFM_PADS-1:0]   ana_conn_next;
    logic [PFM_CODES-1:0]  func_in_next;
    logic [PFM_KIN_W-1:0]  key_in_next;
    logic [PFM_PADS-1:0]   gpio_in_next;
    logic [2:0]            jtag_in_next;

    // ----------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------
    assign req       = avs_read | avs_write;
    assign fsel_word = avs_address[7:2] - FSEL_W0;
    assign fsel_hit  = (avs_address[1:0] == 2'h0)
                       && (avs_address >= PFM_OFS_FSEL0)
                       && (32'(fsel_word) < PFM_FSEL_REGS);
    assign fsel_base = 4 * 32'(fsel_word);

    // Unmapped reads return zero, unmapped writes are dropped
    always_comb begin
        rd_img = '0;
        be_m   = pfm_be_mask(avs_byteenable);
        case (avs_address)
            PFM_OFS_ANALOG: rd_img = {22'h0, ana_en_reg};
            PFM_OFS_MUX_LO: rd_img = mux_en_reg[31:0]; // R5
            PFM_OFS_MUX_HI: rd_img = {29'h0, mux_en_reg[34:32]}; // R5
            PFM_OFS_GPIO:   rd_img = {15'h0, gpio_en_reg & PFM_GPIO_MASK};
            PFM_OFS_KSCAN:  rd_img = {31'h0, kscan_en_reg};
            default: begin
                if (fsel_hit) begin
                    for (int s = 0; s < 4; s++) begin
                        if (fsel_base + s < PFM_PADS) begin
                            rd_img[PFM_SLOT_STEP*s +: PFM_CW] =
                                code_reg[fsel_base + s]; // R6
                        end
                    end
                end
            end
        endcase
        wr_img = (rd_img & ~be_m) | (avs_writedata & be_m);
    end

    // One wait cycle per access, then one cycle low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= '0;
        end else if (req && avs_waitrequest) begin
            avs_readdata <= avs_read ? rd_img : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ana_en_reg   <= PFM_ANALOG_RST;
            mux_en_reg   <= '0;
            gpio_en_reg  <= '0; // R7
            kscan_en_reg <= 1'b0;
            for (int p = 0; p < PFM_PADS; p++) begin
                code_reg[p] <= '0;
            end
        end else if (avs_write && !avs_waitrequest) begin
            case (avs_address)
                PFM_OFS_ANALOG: ana_en_reg <= wr_img[PFM_ANA_W-1:0];
                PFM_OFS_MUX_LO: mux_en_reg[31:0] <= wr_img;
                PFM_OFS_MUX_HI: mux_en_reg[34:32] <= wr_img[2:0];
                PFM_OFS_GPIO:
                    gpio_en_reg <= wr_img[PFM_GPIO_W-1:0] & PFM_GPIO_MASK; // R7
                PFM_OFS_KSCAN:  kscan_en_reg <= wr_img[0];
                default: begin
                    if (fsel_hit) begin
                        for (int s = 0; s < 4; s++) begin
                            if (fsel_base + s < PFM_PADS) begin
                                code_reg[fsel_base + s] <=
                                    wr_img[PFM_SLOT_STEP*s +: PFM_CW]; // R6
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // Pad mode and drive
    // ----------------------------------------------------------
    pfm_pad_select u_select (
        .ana_en      (ana_en_reg),
        .mux_en      (mux_en_reg),
        .gpio_en     (gpio_en_reg),
        .kscan_en    (kscan_en_reg),
        .xtal_in_use (xtal_in_use),
        .pad_mode    (pad_mode)
    );

    always_comb begin
        pad_out_next  = '0;
        pad_oe_next   = '0;
        ana_conn_next = '0;
        for (int p = 0; p < PFM_PADS; p++) begin
            case (pad_mode[p])
                PM_FUNC: begin
                    if (pfm_code_ok(code_reg[p])) begin
                        pad_out_next[p] = func_out[code_reg[p]]; // R12
                        pad_oe_next[p]  = func_oe[code_reg[p]]; // R6
                    end
                end
                PM_ANALOG: ana_conn_next[p] = 1'b1; // R3
                PM_KEY: begin
                    if (PFM_KM[p][5]) begin
                        pad_out_next[p] = keymatrix_output[PFM_KM[p][4:0]]; // R11
                        pad_oe_next[p]  = 1'b1;
                    end
                end
                PM_GPIO: begin
                    pad_out_next[p] = gpio_out[p];
                    pad_oe_next[p]  = gpio_oe[p];
                end
                PM_XTAL: ana_conn_next[p] = 1'b1; // R11
                PM_JTAG: begin
                    if (p == 0) begin
                        pad_out_next[p] = test_data_out; // R2
                        pad_oe_next[p]  = test_data_out_oe;
                    end
                end
                default: ; // Test pad stays an input
            endcase
        end
    end

    pfm_input_route u_route (
        .pad_in       (pad_in),
        .pad_mode     (pad_mode),
        .pad_code     (code_reg),
        .func_in_next (func_in_next),
        .key_in_next  (key_in_next),
        .gpio_in_next (gpio_in_next),
        .jtag_in_next (jtag_in_next)
    );

    // ----------------------------------------------------------
    // Output flops
    // ----------------------------------------------------------
    // One cycle of latency each way; buys glitch-free pads on reconfig
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pad_out            <= '0;
            pad_oe             <= '0;
            analog_pad_connect <= '0;
            adc_input_connect  <= '0;
            pga_input_connect  <= '0;
        end else begin
            pad_out            <= pad_out_next;
            pad_oe             <= pad_oe_next;
            analog_pad_connect <= ana_conn_next;
            adc_input_connect  <= {ana_conn_next[20],
                                   ana_conn_next[15:11]}; // R4
            pga_input_connect  <= ana_conn_next[19:18]; // R4
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            func_in          <= '0;
            keymatrix_input  <= '0;
            gpio_in          <= '0;
            test_data_in     <= 1'b0;
            test_mode_select <= 1'b0;
            test_clock       <= 1'b0;
        end else begin
            func_in          <= func_in_next; // R9
            keymatrix_input  <= key_in_next;
            gpio_in          <= gpio_in_next;
            test_data_in     <= jtag_in_next[0]; // R2
            test_mode_select <= jtag_in_next[1];
            test_clock       <= jtag_in_next[2];
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_test_pad_idle: assert property ( // R10
        !pad_oe[PFM_TEST_PAD])
        else $error("Test pad driven");

    a_pad8_route_ignored: assert property ( // R5
        mux_en_reg[PFM_TEST_PAD] |=> !pad_oe[PFM_TEST_PAD]
                                     && !$past(pad_oe[PFM_TEST_PAD]))
        else $error("Route bit 8 drove the test pad");

    a_jtag_default_map: assert property ( // R1
        (!mux_en_reg[2] && !kscan_en_reg && !gpio_en_reg[2])
        |=> test_mode_select == $past(pad_in[2]))
        else $error("Pad 2 not on JTAG by default");

    a_jtag_dout_pad: assert property ( // R2
        (pad_mode[0] == PM_JTAG) |=> pad_out[0] == $past(test_data_out)
                                     && pad_oe[0] == $past(test_data_out_oe))
        else $error("JTAG data out not on pad 0");

    a_analog_pad_sw: assert property ( // R3
        (ana_en_reg[0] && !mux_en_reg[11]) |=> analog_pad_connect[11]
                                               && !pad_oe[11])
        else $error("Pad 11 not switched to analog");

    a_adc_pga_wire: assert property ( // R4
        (ana_en_reg[9] && !mux_en_reg[20] && ana_en_reg[7] && !mux_en_reg[18])
        |=> adc_input_connect[5] && pga_input_connect[0])
        else $error("Analog line not wired to converter or amplifier");

    a_func_code_drive: assert property ( // R6
        (mux_en_reg[1] && pfm_code_ok(code_reg[1]))
        |=> pad_out[1] == $past(func_out[code_reg[1]]))
        else $error("Pad 1 not driven by its code");

    a_gpio_reset_zero: assert property ( // R7
        $rose(rstn) |-> gpio_en_reg == '0)
        else $error("GPIO enables not zero after reset");

    a_gpio_takes_jtag: assert property ( // R8
        (gpio_en_reg[3] && !mux_en_reg[3] && !kscan_en_reg)
        |=> pad_oe[3] == $past(gpio_oe[3])
            && pad_out[3] == $past(gpio_out[3]) && !test_clock)
        else $error("GPIO did not take pad 3");

    a_code_input_back: assert property ( // R9
        (mux_en_reg[0] && code_reg[0] == 6'h09)
        |=> func_in[9] == $past(pad_in[0]))
        else $error("Code 9 input not returned from pad 0");

    a_keymatrix_drive: assert property ( // R11
        (kscan_en_reg && !mux_en_reg[9])
        |=> pad_oe[9] && pad_out[9] == $past(keymatrix_output[4]))
        else $error("Key matrix line not on pad 9");

    a_route_priority: assert property ( // R12
        (mux_en_reg[12] && ana_en_reg[1]) |=> !analog_pad_connect[12])
        else $error("Routed pad left on analog");

    c_jtag_idle: cover property (pad_mode[1] == PM_JTAG ##1 test_data_in);
    c_func_routed: cover property (mux_en_reg[5] ##1 pad_oe[5]);
    c_key_scan: cover property ($rose(kscan_en_reg));
    c_bus_write: cover property (avs_write && !avs_waitrequest);

endmodule
`default_nettype wire

// ==== sim/pfm_pad_world.sv ====
// Pad world model: external pad drivers and the resolved pad levels.
// Assumes one clock shared with the mux; the pads have no pulls.
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_world (
    input  wire logic [pfm_pkg::PFM_PADS-1:0] ext_en,
    input  wire logic [pfm_pkg::PFM_PADS-1:0] ext_val,
    input  wire logic                         ref_clk,
    input  wire logic [pfm_pkg::PFM_PADS-1:0] pad_out,
    input  wire logic [pfm_pkg::PFM_PADS-1:0] pad_oe,
    output logic [pfm_pkg::PFM_PADS-1:0]      pad_in
);
    import pfm_pkg::*;
    // Undriven pads wander each cycle, so a stale level is never trusted
    logic float_reg = 1'b0;
    always_ff @(posedge ref_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < PFM_PADS; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] :
                        ext_en[i] ? ext_val[i] : float_reg ^ i[0];
        end
    end
endmodule
`default_nettype wire

// ==== sim/pfm_top_tb_top.sv ====
// Pad mux testbench: register tasks, directed pad scenarios.
// Assumes the pad world model resolves every pad wire.
`timescale 1ns/1ps
`default_nettype none
module pfm_top_tb_top;
    import pfm_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, test_data_out = 1'b0, test_data_out_oe = 1'b0;
    logic xtal_in_use = 1'b0, test_data_in, test_mode_select, test_clock;
    logic [PFM_PADS-1:0] pad_in, pad_out, pad_oe, analog_pad_connect;
    logic [PFM_PADS-1:0] gpio_in, gpio_out = '0, gpio_oe = '0;
    logic [PFM_PADS-1:0] ext_en = '0, ext_val = '0;
    logic [PFM_CODES-1:0] func_out = '0, func_oe = '0, func_in;
    logic [PFM_KOUT_W-1:0] keymatrix_output = '0;
    logic [PFM_KIN_W-1:0] keymatrix_input;
    logic [5:0] adc_input_connect;
    logic [1:0] pga_input_connect;
    int num_errors = 0, n_compared = 0;

    always #10 ref_clk = ~ref_clk;

    pfm_top i_pfm_top (.*);
    pfm_pad_world i_pfm_pad_world (.ext_en(ext_en), .ext_val(ext_val),
        .ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_in(pad_in));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low at an edge
    task automatic bus(logic rw, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        if (rw) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk("waitrequest", 1, 0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk($sformatf("readdata@%h", a), avs_readdata, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(PFM_OFS_ANALOG, 32'h60);
        rd(PFM_OFS_GPIO, 32'h0);
        rd(PFM_OFS_MUX_LO, 32'h0);
        rd(8'h40, 32'h0);
        test_data_out <= 1'b1;
        test_data_out_oe <= 1'b1;
        ext_en[3:1] <= 3'b111;
        ext_val[3:1] <= 3'b101;
        settle();
        chk("tdo pad", {pad_oe[0], pad_out[0]}, 2'b11);
        chk("tap in", {test_clock, test_mode_select, test_data_in}, 3'b101);
        chk("jtag in pads", pad_oe[3:1], 3'b000);
        bus(1'b1, PFM_OFS_GPIO, 32'hFFFFFFFF);
        rd(PFM_OFS_GPIO, 32'h1C00F);
        gpio_oe[0] <= 1'b1;
        settle();
        chk("gpio pad0", {pad_oe[0], pad_out[0]}, 2'b10);
        chk("gpio in", gpio_in[3:0], 4'b1010);
        bus(1'b1, PFM_OFS_GPIO, 32'h0);
        // Pad 1 carries code 8 out, pad 0 returns code 9; bit 8 set
        func_out <= '1;
        func_oe <= 41'h100;
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b1;
        bus(1'b1, PFM_OFS_FSEL0, 32'h0809);
        bus(1'b1, PFM_OFS_MUX_LO, 32'h103);
        rd(PFM_OFS_FSEL0, 32'h0809);
        rd(PFM_OFS_MUX_LO, 32'h103);
        settle();
        chk("code8 pad1", {pad_oe[1], pad_out[1]}, 2'b11);
        chk("code9 in", func_in[9], 1'b1);
        chk("pad0 oe", pad_oe[0], 1'b0);
        chk("pad8 oe", pad_oe[PFM_TEST_PAD], 1'b0);
        bus(1'b1, PFM_OFS_MUX_LO, 32'h0);
        bus(1'b1, PFM_OFS_ANALOG, 32'h3FF);
        settle();
        chk("ana pads", analog_pad_connect, 35'h1CF800);
        chk("ana lines", {pga_input_connect, adc_input_connect}, 8'hFF);
        bus(1'b1, PFM_OFS_MUX_LO, 32'h1000);
        settle();
        chk("routed pad12", analog_pad_connect, 35'h1CE800);
        bus(1'b1, PFM_OFS_MUX_LO, 32'h0);
        bus(1'b1, PFM_OFS_ANALOG, 32'h1);
        settle();
        chk("ana pad11", analog_pad_connect, 35'h800);
        chk("ana line0", {pga_input_connect, adc_input_connect}, 8'h01);
        bus(1'b1, PFM_OFS_ANALOG, 32'h0);
        bus(1'b1, PFM_OFS_KSCAN, 32'h1);
        keymatrix_output[0] <= 1'b1;
        settle();
        chk("key out0", {pad_oe[1], pad_out[1]}, 2'b11);
        chk("key in0", keymatrix_input[0], 1'b1);
        bus(1'b1, PFM_OFS_KSCAN, 32'h0);
        xtal_in_use <= 1'b1;
        settle();
        chk("xtal pads", analog_pad_connect[17:16], 2'b11);
        // Mid-run reset: TAP drive parked so no stale pad 0 level is expected
        @(posedge ref_clk);
        rstn <= 1'b0;
        test_data_out <= 1'b0;
        test_data_out_oe <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(PFM_OFS_ANALOG, 32'h60);
        conclude();
    end

    // Whole run is under a hundred cycles; 10000 cycles is far past that
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
